// >>> hw/oss_regs.vh
// Register map, field positions, reset values and source codes of the clock source selector
`ifndef OSS_REGS_VH
`define OSS_REGS_VH

`define OSS_OFF_CTRL     12'h000
`define OSS_OFF_DIV      12'h004
`define OSS_OFF_TUNE     12'h008
`define OSS_OFF_KEY      12'h00C

`define OSS_KEY1         8'h46
`define OSS_KEY2         8'h57

`define OSS_CFG_MODE_LO  0
`define OSS_CFG_CKSM_LO  6
`define OSS_CFG_SRC_LO   8
`define OSS_CFG_OSCIO    5
`define OSS_CFG_IO_LOCK_ONE_WAY_CFG  12

`define OSS_CTL_CUR_LO   12
`define OSS_CTL_REQ_LO   8
`define OSS_CTL_CLOCK_SELECT_LOCK  7
`define OSS_CTL_IO_LOCK_A   6
`define OSS_CTL_PLLLOCK  5
`define OSS_CTL_CF       3
`define OSS_CTL_PSLEEP   2
`define OSS_CTL_SECEN    1
`define OSS_CTL_SWEN     0

`define OSS_DIV_RC_LO    8
`define OSS_DIV_PLLEN    5
`define OSS_DIV_MULT_LO  0
`define OSS_DIV_RC_RST   3'h1
`define OSS_MULT_X4      2'h0
`define OSS_MULT_X6      2'h1
`define OSS_MULT_X8      2'h2

`define OSS_TUNE_SELF    15
`define OSS_TUNE_TRIM_W  6

`define OSS_MODE_EC      2'h0
`define OSS_MODE_XT      2'h1
`define OSS_MODE_HS      2'h2
`define OSS_MODE_NONE    2'h3

`define OSS_SRC_FRC      3'h0
`define OSS_SRC_FAST_RC_WITH_PLL   3'h1
`define OSS_SRC_PRI      3'h2
`define OSS_SRC_PRIPLL   3'h3
`define OSS_SRC_SEC      3'h4
`define OSS_SRC_LOW_POWER_INTERNAL_RC     3'h5
`define OSS_SRC_RSVD     3'h6
`define OSS_SRC_FAST_RC_DIVIDED   3'h7

`define OSS_FRC_HZ       8000000
`define OSS_PLL_HZ       96000000
`define OSS_USB_HZ       48000000

`endif

// >>> hw/oss_top.v
// Clock source selector: configuration capture, switch sequencer and APB registers
`timescale 1ns/1ps
`include "oss_regs.vh"

module oss_top (
    // Clock, reset, freeze
    input  wire        pclk,
    input  wire        presetn,
    input  wire        ce,
    // APB slave
    input  wire [11:0] paddr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Nonvolatile configuration word
    input  wire [15:0] cfg_word,
    // Oscillator status, one bit per source code
    input  wire [7:0]  src_running,
    input  wire        pll_locked,
    input  wire        clk_fail_det,
    // Clock tree controls
    output reg  [2:0]  sys_src_sel,
    output reg         clk_hold,
    output reg  [2:0]  frc_div_sel,
    output reg         pll_enable,
    output reg  [1:0]  pll_mult_sel,
    output reg         usb_pll_enable,
    output reg  [5:0]  frc_trim,
    output reg         frc_selftune_en,
    output reg         instr_clk,
    output reg         osc_out_pin_o,
    output reg         osc_out_pin_oe,
    output reg         io_lock_a,
    output reg         primary_sleep_enable,
    output reg         secondary_enable,
    output reg         fail_safe_monitor
);

    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_WAIT = 2'h1;
    localparam [1:0] ST_HOLD = 2'h2;

    // Maps a configured or requested code onto a usable source
    function [2:0] eff_src;
        input [2:0] code;
        input [1:0] mode;
        begin
            if (code == `OSS_SRC_RSVD)
                eff_src = `OSS_SRC_FAST_RC_DIVIDED;
            else if ((code == `OSS_SRC_PRI || code == `OSS_SRC_PRIPLL) &&
                     mode == `OSS_MODE_NONE)
                eff_src = `OSS_SRC_FRC;
            else
                eff_src = code;
        end
    endfunction

    // A code that the mapper would change cannot be switched to
    function valid_target;
        input [2:0] code;
        input [1:0] mode;
        begin
            valid_target = (eff_src(code, mode) == code);
        end
    endfunction

    // Sources whose clock passes through the PLL
    function is_pll;
        input [2:0] code;
        begin
            is_pll = (code == `OSS_SRC_FAST_RC_WITH_PLL) || (code == `OSS_SRC_PRIPLL);
        end
    endfunction

    // Byte-lane merge of a 16-bit register
    function [15:0] merge16;
        input [15:0] old;
        input [15:0] wd;
        input [1:0]  strb;
        begin
            merge16[7:0]  = strb[0] ? wd[7:0]  : old[7:0];
            merge16[15:8] = strb[1] ? wd[15:8] : old[15:8];
        end
    endfunction

    // Configuration snapshot (taken once so later config changes cannot move the clock), sequencer state and register fields
    reg         cfg_done_reg;
    reg [1:0]   cfg_mode_reg;
    reg [1:0]   cfg_cksm_reg;
    reg         cfg_oscio_reg;
    reg         cfg_io_lock_one_way_cfg_reg;
    reg [2:0]   cur_reg;
    reg [2:0]   req_reg;
    reg [2:0]   target_reg;
    reg [1:0]   state_reg;
    reg         clock_select_lock_reg;
    reg         io_lock_a_reg;
    reg         plllock_reg;
    reg         cf_reg;
    reg         psleep_reg;
    reg         secen_reg;
    reg         swen_reg;
    reg [2:0]   rcdiv_reg;
    reg         pllen_reg;
    reg [1:0]   mult_reg;
    reg [5:0]   trim_reg;
    reg         self_reg;
    // Unlock sequence state and instruction clock divider flop
    reg         key1_seen_reg;
    reg         unlock_reg;
    reg         fclk_reg;

    wire [2:0]  cfg_src   = cfg_word[`OSS_CFG_SRC_LO+2:`OSS_CFG_SRC_LO];
    wire [1:0]  cfg_mode  = cfg_word[`OSS_CFG_MODE_LO+1:`OSS_CFG_MODE_LO];
    wire        sw_allow  = ~cfg_cksm_reg[1];
    wire        fail_safe_monitor_en   = (cfg_cksm_reg == 2'h0);
    wire        sel_lock  = fail_safe_monitor_en & clock_select_lock_reg;
    wire        sw_busy   = (state_reg != ST_IDLE);
    wire        fail_ev   = fail_safe_monitor_en & clk_fail_det & cfg_done_reg;

    wire        acc       = psel & penable & pready;
    wire        wr_acc    = acc & pwrite;
    // Decode on the full word address, so aliases are refused
    wire        hit_ctrl  = (paddr == `OSS_OFF_CTRL);
    wire        hit_div   = (paddr == `OSS_OFF_DIV);
    wire        hit_tune  = (paddr == `OSS_OFF_TUNE);
    wire        hit_key   = (paddr == `OSS_OFF_KEY);
    wire        mapped    = hit_ctrl | hit_div | hit_tune | hit_key;

    wire [15:0] ctrl_val  = {1'b0, cur_reg, 1'b0, req_reg,
                             clock_select_lock_reg, io_lock_a_reg, plllock_reg, 1'b0,
                             cf_reg, psleep_reg, secen_reg, swen_reg};
    wire [15:0] div_val   = {5'h00, rcdiv_reg, 2'h0, pllen_reg, 3'h0, mult_reg};
    wire [15:0] tune_val  = {self_reg, 9'h000, trim_reg};
    // Merged per byte lane so a partial write keeps the other fields
    wire [15:0] wctl      = merge16(ctrl_val, pwdata[15:0], pstrb[1:0]);
    wire [15:0] wdiv      = merge16(div_val, pwdata[15:0], pstrb[1:0]);
    wire [15:0] wtun      = merge16(tune_val, pwdata[15:0], pstrb[1:0]);
    wire        ctl_wr    = wr_acc & hit_ctrl & cfg_done_reg;
    wire        cf_clr    = ctl_wr & pstrb[0] & ~pwdata[`OSS_CTL_CF];
    // A second start while one is pending is ignored rather than retargeted
    wire        sw_start  = ctl_wr & wctl[`OSS_CTL_SWEN] & sw_allow &
                            ~sel_lock & ~sw_busy & ~swen_reg;

    reg  [31:0] rd_mux;

    always @* begin
        rd_mux = 32'h0000_0000;
        if (hit_ctrl)
            rd_mux = {16'h0000, ctrl_val};
        else if (hit_div)
            rd_mux = {16'h0000, div_val};
        else if (hit_tune)
            rd_mux = {16'h0000, tune_val};
    end

    // APB: no wait state; read data is registered in the setup phase so that it comes from a flop
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready <= psel & ~penable;
            if (psel & ~penable) begin
                prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
                pslverr <= ~mapped;
            end
        end
    end

    // Configuration capture on the first enabled edge after reset release
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_done_reg    <= 1'b0;
            cfg_mode_reg    <= `OSS_MODE_NONE;
            cfg_cksm_reg    <= 2'h3;
            cfg_oscio_reg   <= 1'b0;
            cfg_io_lock_one_way_cfg_reg <= 1'b1;
        end else if (ce && !cfg_done_reg) begin
            cfg_done_reg    <= 1'b1;
            cfg_mode_reg    <= cfg_mode;
            cfg_cksm_reg    <= cfg_word[`OSS_CFG_CKSM_LO+1:`OSS_CFG_CKSM_LO];
            cfg_oscio_reg   <= cfg_word[`OSS_CFG_OSCIO];
            cfg_io_lock_one_way_cfg_reg <= cfg_word[`OSS_CFG_IO_LOCK_ONE_WAY_CFG];
        end
    end

    // Switch sequencer and current source
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg  <= ST_IDLE;
            cur_reg    <= `OSS_SRC_FAST_RC_DIVIDED;
            target_reg <= `OSS_SRC_FAST_RC_DIVIDED;
            swen_reg   <= 1'b0;
            clk_hold   <= 1'b1;
        end else if (ce) begin
            if (!cfg_done_reg) begin
                cur_reg  <= eff_src(cfg_src, cfg_mode);
                clk_hold <= 1'b0;
            end else if (fail_ev) begin
                // Fall back to the internal RC, which cannot fail
                cur_reg   <= `OSS_SRC_FRC;
                state_reg <= ST_IDLE;
                swen_reg  <= 1'b0;
                clk_hold  <= 1'b0;
            end else begin
                case (state_reg)
                    ST_IDLE: begin
                        if (sw_start) begin
                            swen_reg   <= 1'b1;
                            target_reg <= wctl[`OSS_CTL_REQ_LO+2:`OSS_CTL_REQ_LO];
                            state_reg  <= ST_WAIT;
                        end
                    end
                    ST_WAIT: begin
                        // No time limit here: a source that never starts
                        // leaves the switch pending until a monitored failure or reset
                        if (!valid_target(target_reg, cfg_mode_reg) ||
                            target_reg == cur_reg) begin
                            swen_reg  <= 1'b0;
                            state_reg <= ST_IDLE;
                        end else if (src_running[target_reg]) begin
                            clk_hold  <= 1'b1;
                            state_reg <= ST_HOLD;
                        end
                    end
                    ST_HOLD: begin
                        // Old clock is stopped here; cur_reg moves as the hold drops, and sys_src_sel follows one cycle later
                        cur_reg   <= target_reg;
                        swen_reg  <= 1'b0;
                        clk_hold  <= 1'b0;
                        state_reg <= ST_IDLE;
                    end
                    default: begin
                        state_reg <= ST_IDLE;
                        clk_hold  <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Control register fields
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_reg       <= `OSS_SRC_FAST_RC_DIVIDED;
            clock_select_lock_reg   <= 1'b0;
            io_lock_a_reg    <= 1'b0;
            plllock_reg   <= 1'b0;
            cf_reg        <= 1'b0;
            psleep_reg    <= 1'b0;
            secen_reg     <= 1'b0;
            key1_seen_reg <= 1'b0;
            unlock_reg    <= 1'b0;
        end else if (ce) begin
            if (!cfg_done_reg)
                req_reg <= cfg_src;
            else if (ctl_wr && !sel_lock && !sw_busy)
                req_reg <= wctl[`OSS_CTL_REQ_LO+2:`OSS_CTL_REQ_LO];
            if (ctl_wr && wctl[`OSS_CTL_CLOCK_SELECT_LOCK])
                clock_select_lock_reg <= 1'b1;
            // Set wins over a clear in the same cycle, so no failure is lost
            cf_reg <= fail_ev | (cf_reg & ~cf_clr);
            if (ctl_wr) begin
                psleep_reg <= wctl[`OSS_CTL_PSLEEP];
                secen_reg  <= wctl[`OSS_CTL_SECEN];
            end
            // Two key bytes in a row arm a single control write for the I/O lock
            if (wr_acc && hit_key && pstrb[0]) begin
                key1_seen_reg <= (pwdata[7:0] == `OSS_KEY1);
                unlock_reg    <= key1_seen_reg & (pwdata[7:0] == `OSS_KEY2);
            end else if (ctl_wr) begin
                key1_seen_reg <= 1'b0;
                unlock_reg    <= 1'b0;
                if (unlock_reg) begin
                    if (wctl[`OSS_CTL_IO_LOCK_A])
                        io_lock_a_reg <= 1'b1;
                    else if (!cfg_io_lock_one_way_cfg_reg)
                        io_lock_a_reg <= 1'b0;
                end
            end else if (wr_acc) begin
                key1_seen_reg <= 1'b0;
                unlock_reg    <= 1'b0;
            end
            // Drops while busy so software never reads a stale lock
            plllock_reg <= is_pll(cur_reg) & ~sw_busy & pll_locked & cfg_done_reg;
        end
    end

    // Divider and tuning registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rcdiv_reg <= `OSS_DIV_RC_RST;
            pllen_reg <= 1'b0;
            mult_reg  <= `OSS_MULT_X4;
            trim_reg  <= 6'h00;
            self_reg  <= 1'b0;
        end else if (ce && cfg_done_reg) begin
            // Divider stays writable under the lock; only PLL fields are guarded
            if (wr_acc && hit_div) begin
                rcdiv_reg <= wdiv[`OSS_DIV_RC_LO+2:`OSS_DIV_RC_LO];
                if (!sel_lock) begin
                    pllen_reg <= wdiv[`OSS_DIV_PLLEN];
                    // Reserved multiplier code keeps the previous factor
                    if (wdiv[1:0] != 2'h3)
                        mult_reg <= wdiv[`OSS_DIV_MULT_LO+1:`OSS_DIV_MULT_LO];
                end
            end
            if (wr_acc && hit_tune) begin
                trim_reg <= wtun[`OSS_TUNE_TRIM_W-1:0];
                self_reg <= wtun[`OSS_TUNE_SELF];
            end
        end
    end

    // Clock tree outputs and instruction clock
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_src_sel          <= `OSS_SRC_FAST_RC_DIVIDED;
            frc_div_sel          <= `OSS_DIV_RC_RST;
            pll_enable           <= 1'b0;
            pll_mult_sel         <= `OSS_MULT_X4;
            usb_pll_enable       <= 1'b0;
            frc_trim             <= 6'h00;
            frc_selftune_en      <= 1'b0;
            fclk_reg             <= 1'b0;
            instr_clk            <= 1'b0;
            osc_out_pin_o        <= 1'b0;
            osc_out_pin_oe       <= 1'b0;
            io_lock_a            <= 1'b0;
            primary_sleep_enable <= 1'b0;
            secondary_enable     <= 1'b0;
            fail_safe_monitor    <= 1'b0;
        end else if (ce) begin
            // Registered, one cycle behind the register fields; frc_div_sel is 0 unless the current source is the divided RC or the RC with PLL
            sys_src_sel     <= cur_reg;
            frc_div_sel     <= (cur_reg == `OSS_SRC_FAST_RC_DIVIDED ||
                                cur_reg == `OSS_SRC_FAST_RC_WITH_PLL) ? rcdiv_reg : 3'h0;
            // PLL starts ahead of a switch onto a PLL source so it can lock first
            pll_enable      <= is_pll(cur_reg) | (sw_busy & is_pll(target_reg));
            pll_mult_sel    <= mult_reg;
            usb_pll_enable  <= pllen_reg;
            frc_trim        <= trim_reg;
            frc_selftune_en <= self_reg;
            // Processor clock stands still while held, so the halved clock does too
            if (!clk_hold) begin
                fclk_reg  <= ~fclk_reg;
                instr_clk <= ~fclk_reg;
            end
            // Pin is free for clock out unless a crystal sits on it
            osc_out_pin_oe <= cfg_done_reg & cfg_oscio_reg &
                              (cfg_mode_reg == `OSS_MODE_EC ||
                               cfg_mode_reg == `OSS_MODE_NONE);
            osc_out_pin_o  <= cfg_done_reg & cfg_oscio_reg & ~fclk_reg;
            io_lock_a            <= io_lock_a_reg;
            primary_sleep_enable <= psleep_reg;
            secondary_enable     <= secen_reg;
            fail_safe_monitor    <= fail_safe_monitor_en & cfg_done_reg;
        end
    end

endmodule

// >>> tb/oss_top_monitor.sv
// Port-level checker for the clock source selector
`timescale 1ns/1ps

module oss_top_monitor (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // Bus handshake
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    // Configuration and status
    input wire logic [15:0] cfg_word,
    input wire logic        clk_fail_det,
    // Clock tree
    input wire logic [2:0]  sys_src_sel,
    input wire logic        clk_hold,
    input wire logic        instr_clk,
    input wire logic        osc_out_pin_oe,
    input wire logic        fail_safe_monitor
);
    logic [2:0] up_cnt_reg;
    logic [3:0] recent_reg;
    logic       settled;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Source changes are legal only a few cycles after a hold pulse or a monitored failure
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up_cnt_reg <= 3'h0;
            recent_reg <= 4'h0;
        end else begin
            if (up_cnt_reg != 3'h7) begin
                up_cnt_reg <= up_cnt_reg + 3'h1;
            end
            recent_reg <= {recent_reg[2:0], clk_hold | (clk_fail_det & fail_safe_monitor)};
        end
    end
    assign settled = (up_cnt_reg == 3'h7);

    property p_instr_div;
        !$past(clk_hold) && !clk_hold |-> instr_clk != $past(instr_clk);
    endproperty
    a_instr_div: assert property (p_instr_div)
        else $error("instruction clock did not toggle");
    property p_hold_pulse;
        $rose(clk_hold) |=> !clk_hold;
    endproperty
    a_hold_pulse: assert property (p_hold_pulse)
        else $error("hold pulse longer than one cycle");
    property p_sel_needs_hold;
        $changed(sys_src_sel) |-> recent_reg != 4'h0;
    endproperty
    a_sel_needs_hold: assert property (p_sel_needs_hold)
        else $error("source changed without a hold");
    property p_no_switch;
        cfg_word[7] |-> !$rose(clk_hold);
    endproperty
    a_no_switch: assert property (p_no_switch)
        else $error("switch while switching disabled");
    property p_monitor_cfg;
        settled |-> fail_safe_monitor == (cfg_word[7:6] == 2'b00);
    endproperty
    a_monitor_cfg: assert property (p_monitor_cfg)
        else $error("monitor enable differs from config");
    property p_fail_frc;
        settled && fail_safe_monitor && clk_fail_det |-> ##[1:3] sys_src_sel == 3'h0;
    endproperty
    a_fail_frc: assert property (p_fail_frc)
        else $error("failure did not fall back to rc");
    property p_fail_off;
        settled && !fail_safe_monitor && clk_fail_det |=> $stable(sys_src_sel) [*3];
    endproperty
    a_fail_off: assert property (p_fail_off)
        else $error("source moved with monitor off");
    property p_ready_setup;
        psel && !penable |=> pready;
    endproperty
    a_ready_setup: assert property (p_ready_setup)
        else $error("no ready after setup");
    property p_oe_cfg;
        settled |-> osc_out_pin_oe == (cfg_word[5] && cfg_word[1:0] != 2'b01
                                       && cfg_word[1:0] != 2'b10);
    endproperty
    a_oe_cfg: assert property (p_oe_cfg)
        else $error("pin drive differs from config");

    c_switch: cover property ($rose(clk_hold));
    c_fail: cover property (fail_safe_monitor && clk_fail_det);
    c_oe: cover property (osc_out_pin_oe && instr_clk);
endmodule

bind oss_top oss_top_monitor u_mon (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
    .cfg_word(cfg_word), .clk_fail_det(clk_fail_det), .sys_src_sel(sys_src_sel),
    .clk_hold(clk_hold), .instr_clk(instr_clk), .osc_out_pin_oe(osc_out_pin_oe),
    .fail_safe_monitor(fail_safe_monitor)
);

// >>> tb/tb_oss_top.sv
// Self-checking testbench of the clock source selector
`timescale 1ns/1ps
`include "oss_regs.vh"

module tb_oss_top;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [15:0] cfg_word = 16'hFFFF;
    logic [7:0]  src_running = 8'hFF;
    logic        pll_locked = 1'b0;
    logic        clk_fail_det = 1'b0;
    logic [2:0]  sys_src_sel;
    logic        io_lock_a;
    logic [2:0]  frc_div_sel;
    logic        usb_pll_enable;
    logic        instr_clk;
    logic [31:0] rd_q;
    logic        rd_err;
    logic [2:0]  tgt [0:5] = '{3'h6, 3'h2, 3'h4, 3'h7, 3'h1, 3'h0};
    logic [2:0]  cur [0:5] = '{3'h5, 3'h5, 3'h4, 3'h7, 3'h1, 3'h0};
    int          failures = 0;
    int          checked = 0;
    int          cycles = 0;
    int          i;
    localparam logic [11:0] CTL = `OSS_OFF_CTRL;

    always #5 pclk = ~pclk;

    oss_top u_oss_top (
        .pclk(pclk), .presetn(presetn), .ce(1'b1), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cfg_word(cfg_word),
        .src_running(src_running), .pll_locked(pll_locked), .clk_fail_det(clk_fail_det),
        .sys_src_sel(sys_src_sel), .clk_hold(), .frc_div_sel(frc_div_sel), .pll_enable(),
        .pll_mult_sel(), .usb_pll_enable(usb_pll_enable), .frc_trim(), .frc_selftune_en(),
        .instr_clk(instr_clk), .osc_out_pin_o(), .osc_out_pin_oe(), .io_lock_a(io_lock_a),
        .primary_sleep_enable(), .secondary_enable(), .fail_safe_monitor()
    );

    task automatic print_verdict();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Hung handshakes end here instead of stalling the run
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            print_verdict();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd_q    = prdata;
        rd_err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rd_q & m, e);
    endtask

    // Request a switch, then poll until hardware drops the enable bit
    task automatic sw(input logic [2:0] code);
        apb(1'b1, CTL, {21'h0, code, 8'h01});
        for (int n = 0; n < 20; n++) begin
            apb(1'b0, CTL, 32'h0);
            if (rd_q[0] === 1'b0) begin
                break;
            end
        end
        repeat (3) @(posedge pclk);
    endtask

    task automatic rst(input logic [15:0] cfg);
        presetn  <= 1'b0;
        cfg_word <= cfg;
        repeat (16) @(posedge pclk);
        presetn  <= 1'b1;
        repeat (3) @(posedge pclk);
    endtask

    task automatic fail_pulse();
        clk_fail_det <= 1'b1;
        @(posedge pclk);
        clk_fail_det <= 1'b0;
        repeat (3) @(posedge pclk);
    endtask

    initial begin
        rst(16'hFFFF);
        rd_chk(CTL, 32'hFFFFFFFF, 32'h7700);
        check({29'h0, sys_src_sel}, 32'h7);
        check({29'h0, frc_div_sel}, 32'h1);
        sw(3'h0);
        rd_chk(CTL, 32'h7000, 32'h7000);
        apb(1'b0, 12'h010, 32'h0);
        check({rd_q[31:1], rd_err}, 32'h1);
        apb(1'b1, `OSS_OFF_DIV, 32'h0000_0321);
        rd_chk(`OSS_OFF_DIV, 32'hFFFF, 32'h0321);
        check({29'h0, frc_div_sel}, 32'h3);
        check({31'h0, usb_pll_enable}, 32'h1);
        apb(1'b1, `OSS_OFF_TUNE, 32'h0000_8015);
        rd_chk(`OSS_OFF_TUNE, 32'hFFFF, 32'h8015);
        $display("test erased config done");

        rst(16'h0003);
        pll_locked <= 1'b1;
        rd_chk(CTL, 32'hFFFF, 32'h0000);
        // Target not running yet: the switch must stay pending
        src_running <= 8'hDF;
        apb(1'b1, CTL, 32'h0501);
        repeat (10) @(posedge pclk);
        rd_chk(CTL, 32'h7001, 32'h0001);
        src_running <= 8'hFF;
        sw(3'h5);
        rd_chk(CTL, 32'h7000, 32'h5000);
        for (i = 0; i < 6; i++) begin
            sw(tgt[i]);
            rd_chk(CTL, 32'h7000, {17'h0, cur[i], 12'h0});
            check({29'h0, sys_src_sel}, {29'h0, cur[i]});
        end
        rd_chk(CTL, 32'h20, 32'h0);
        sw(3'h4);
        fail_pulse();
        rd_chk(CTL, 32'h7008, 32'h0008);
        apb(1'b1, CTL, 32'h0000);
        rd_chk(CTL, 32'h8, 32'h0);
        apb(1'b1, CTL, 32'h0008);
        rd_chk(CTL, 32'h8, 32'h0);
        apb(1'b1, CTL, 32'h0080);
        apb(1'b1, CTL, 32'h0000);
        rd_chk(CTL, 32'h80, 32'h80);
        sw(3'h5);
        rd_chk(CTL, 32'h7000, 32'h0000);
        $display("test monitored switching done");

        rst(16'h0242);
        rd_chk(CTL, 32'h7700, 32'h2200);
        apb(1'b1, CTL, 32'h0280);
        sw(3'h5);
        rd_chk(CTL, 32'h7000, 32'h5000);
        fail_pulse();
        rd_chk(CTL, 32'h8, 32'h0);
        apb(1'b1, CTL, 32'h0540);
        rd_chk(CTL, 32'h40, 32'h0);
        apb(1'b1, `OSS_OFF_KEY, {24'h0, `OSS_KEY1});
        apb(1'b1, `OSS_OFF_KEY, {24'h0, `OSS_KEY2});
        apb(1'b1, CTL, 32'h0540);
        rd_chk(CTL, 32'h40, 32'h40);
        check({31'h0, io_lock_a}, 32'h1);
        apb(1'b1, CTL, 32'h0500);
        rd_chk(CTL, 32'h40, 32'h40);
        $display("test unmonitored switching done");

        rst(16'h03E0);
        rd_chk(CTL, 32'h7000, 32'h3000);
        @(posedge pclk);
        rd_q[0] = instr_clk;
        @(posedge pclk);
        check({31'h0, instr_clk ^ rd_q[0]}, 32'h1);
        $display("test primary with pll done");
        print_verdict();
    end
endmodule
